/* File: src/rc_compressor_regs.vh */
// Register offsets, field positions, reset values and timing constants of the range compressor
`ifndef RC_COMPRESSOR_REGS_VH
`define RC_COMPRESSOR_REGS_VH

`define RC_ADDR_ENABLE_THRESHOLD 8'h44
`define RC_ADDR_HOLD_TIME 8'h45
`define RC_ADDR_ATTACK_DECAY 8'h46

`define RC_BIT_RESERVED_TOP 7
`define RC_BIT_ENABLE_LEFT 6
`define RC_BIT_ENABLE_RIGHT 5
`define RC_THR_MSB 4
`define RC_THR_LSB 2
`define RC_HYST_MSB 1
`define RC_HYST_LSB 0
`define RC_HOLD_MSB 6
`define RC_HOLD_LSB 3
`define RC_ATTACK_MSB 7
`define RC_ATTACK_LSB 4
`define RC_DECAY_MSB 3
`define RC_DECAY_LSB 0

`define RC_RESET_ENABLE_THRESHOLD 8'h0F
`define RC_RESET_HOLD_TIME 8'h38
`define RC_RESET_ATTACK_DECAY 8'h00

// Threshold in dB below full scale: step per code and the clamp value
`define RC_THR_STEP_DB 5'h03
`define RC_THR_CLAMP_CODE 3'h6

// Hold lengths in playback word clocks
`define RC_HOLD_BASE_WCLK 18'h00020
`define RC_HOLD_CODE13_WCLK 18'h18000
`define RC_HOLD_CODE14_WCLK 18'h20000
`define RC_HOLD_CODE15_WCLK 18'h28000
`define RC_HOLD_LAST_SHIFT_CODE 4'hC

// Gain in fixed point dB with 21 fractional bits: 4 dB and 0.015625 dB per word clock
`define RC_GAIN_WIDTH 28
`define RC_ATTACK_BASE_STEP 28'h0800000
`define RC_DECAY_BASE_STEP 28'h0008000
`define RC_GAIN_MAX 28'hFFFFFFF

`endif

/* File: src/rc_channel.v */
// One channel of the range compressor: hold timer and gain reduction ramp
`timescale 1ns/10ps
`include "rc_compressor_regs.vh"

module rc_channel (
	clk,
	resetn,
	enable,
	sampleTick,
	levelAtten,
	thresholdDb,
	hysteresisDb,
	holdLength,
	attackStep,
	decayStep,
	gainReduction,
	holding
);
	input wire clk;
	input wire resetn;
	input wire enable;
	input wire sampleTick;
	input wire [7:0] levelAtten;
	input wire [4:0] thresholdDb;
	input wire [1:0] hysteresisDb;
	input wire [17:0] holdLength;
	input wire [27:0] attackStep;
	input wire [27:0] decayStep;
	output reg [27:0] gainReduction;
	output reg holding;

	reg [17:0] hold_reg;
	reg [17:0] hold_next;
	reg [27:0] gain_next;
	wire [7:0] releaseLevel;
	wire overThreshold;
	wire underRelease;
	wire [28:0] gainSum;

	// Level is attenuation below full scale, so a smaller figure is a louder signal
	assign overThreshold = levelAtten < {3'h0, thresholdDb};
	assign releaseLevel = {3'h0, thresholdDb} + {6'h00, hysteresisDb};
	assign underRelease = levelAtten > releaseLevel;
	assign gainSum = {1'b0, gainReduction} + {1'b0, attackStep};

	always @* begin
		hold_next = hold_reg;
		gain_next = gainReduction;
		if (!enable) begin
			hold_next = 18'h00000;
			gain_next = 28'h0000000;
		end else if (sampleTick) begin
			if (overThreshold) begin
				hold_next = holdLength;
				gain_next = gainSum[28] ? `RC_GAIN_MAX : gainSum[27:0];
			end else if (hold_reg != 18'h00000) begin
				hold_next = hold_reg - 18'h00001;
			end else if (underRelease) begin
				gain_next = (gainReduction > decayStep) ? gainReduction - decayStep :
					28'h0000000;
			end
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hold_reg <= 18'h00000;
			gainReduction <= 28'h0000000;
			holding <= 1'b0;
		end else begin
			hold_reg <= hold_next;
			gainReduction <= gain_next;
			holding <= hold_next != 18'h00000;
		end
	end

endmodule

/* File: src/rc_compressor_ctrl.v */
// Control registers and two-channel range compressor of the playback path
`timescale 1ns/10ps
`include "rc_compressor_regs.vh"

module rc_compressor_ctrl (
	clk,
	resetn,
	regAddr,
	regWrData,
	regWrite,
	regRead,
	regRdData,
	sampleTick,
	levelAttenLeft,
	levelAttenRight,
	volLinkRequest,
	volLinkMode,
	compressLeft,
	compressRight,
	gainReductionLeft,
	gainReductionRight,
	holdingLeft,
	holdingRight,
	thresholdDb,
	hysteresisDb
);
	input wire clk;
	input wire resetn;
	input wire [7:0] regAddr;
	input wire [7:0] regWrData;
	input wire regWrite;
	input wire regRead;
	output reg [7:0] regRdData;
	input wire sampleTick;
	input wire [7:0] levelAttenLeft;
	input wire [7:0] levelAttenRight;
	input wire [1:0] volLinkRequest;
	output reg [1:0] volLinkMode;
	output reg compressLeft;
	output reg compressRight;
	output wire [27:0] gainReductionLeft;
	output wire [27:0] gainReductionRight;
	output wire holdingLeft;
	output wire holdingRight;
	output reg [4:0] thresholdDb;
	output reg [1:0] hysteresisDb;

	////////////////////////////////////////////////////////////////////////////////

	reg [7:0] enThr_reg;
	reg [3:0] holdCode_reg;
	reg [7:0] atkDec_reg;
	reg [7:0] rdData_next;
	reg [17:0] holdLength_reg;
	reg [27:0] attackStep_reg;
	reg [27:0] decayStep_reg;

	localparam [7:0] HOLD_TIME_RESET = `RC_RESET_HOLD_TIME;

	// Threshold magnitude in dB below full scale
	function [4:0] decodeThreshold;
		input [2:0] code;
		reg [2:0] clamped;
		begin
			clamped = (code > `RC_THR_CLAMP_CODE) ? `RC_THR_CLAMP_CODE : code;
			decodeThreshold = `RC_THR_STEP_DB * ({2'h0, clamped} + 5'h01);
		end
	endfunction

	// Hold length in playback word clocks, zero meaning no hold
	function [17:0] decodeHold;
		input [3:0] code;
		begin
			case (code)
				4'h0: decodeHold = 18'h00000;
				4'hD: decodeHold = `RC_HOLD_CODE13_WCLK;
				4'hE: decodeHold = `RC_HOLD_CODE14_WCLK;
				4'hF: decodeHold = `RC_HOLD_CODE15_WCLK;
				default: decodeHold = `RC_HOLD_BASE_WCLK << (code - 4'h1);
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register file

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			enThr_reg <= `RC_RESET_ENABLE_THRESHOLD;
			holdCode_reg <= HOLD_TIME_RESET[`RC_HOLD_MSB:`RC_HOLD_LSB];
			atkDec_reg <= `RC_RESET_ATTACK_DECAY;
		end else if (regWrite) begin
			case (regAddr)
				`RC_ADDR_ENABLE_THRESHOLD: begin
					enThr_reg <= regWrData;
				end
				`RC_ADDR_HOLD_TIME: begin
					// Reserved bits of this register are read-only zero
					holdCode_reg <= regWrData[`RC_HOLD_MSB:`RC_HOLD_LSB];
				end
				`RC_ADDR_ATTACK_DECAY: begin
					atkDec_reg <= regWrData;
				end
				default: begin
				end
			endcase
		end
	end

	always @* begin
		case (regAddr)
			`RC_ADDR_ENABLE_THRESHOLD: rdData_next = enThr_reg;
			`RC_ADDR_HOLD_TIME: rdData_next = {1'b0, holdCode_reg, 3'h0};
			`RC_ADDR_ATTACK_DECAY: rdData_next = atkDec_reg;
			default: rdData_next = 8'h00;
		endcase
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			regRdData <= 8'h00;
		end else if (regRead) begin
			regRdData <= rdData_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decoded settings, registered so every output leaves a flip-flop

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			compressLeft <= 1'b0;
			compressRight <= 1'b0;
			thresholdDb <= 5'h00;
			hysteresisDb <= 2'h0;
			holdLength_reg <= 18'h00000;
			attackStep_reg <= 28'h0000000;
			decayStep_reg <= 28'h0000000;
			volLinkMode <= 2'h0;
		end else begin
			compressLeft <= enThr_reg[`RC_BIT_ENABLE_LEFT];
			compressRight <= enThr_reg[`RC_BIT_ENABLE_RIGHT];
			thresholdDb <= decodeThreshold(enThr_reg[`RC_THR_MSB:`RC_THR_LSB]);
			hysteresisDb <= enThr_reg[`RC_HYST_MSB:`RC_HYST_LSB];
			holdLength_reg <= decodeHold(holdCode_reg);
			attackStep_reg <= `RC_ATTACK_BASE_STEP >>
				atkDec_reg[`RC_ATTACK_MSB:`RC_ATTACK_LSB];
			decayStep_reg <= `RC_DECAY_BASE_STEP >>
				atkDec_reg[`RC_DECAY_MSB:`RC_DECAY_LSB];
			// Linking is forced off whenever either channel compresses
			if (enThr_reg[`RC_BIT_ENABLE_LEFT] || enThr_reg[`RC_BIT_ENABLE_RIGHT]) begin
				volLinkMode <= 2'h0;
			end else begin
				volLinkMode <= volLinkRequest;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channels

	rc_channel leftChannel (
		.clk(clk),
		.resetn(resetn),
		.enable(compressLeft),
		.sampleTick(sampleTick),
		.levelAtten(levelAttenLeft),
		.thresholdDb(thresholdDb),
		.hysteresisDb(hysteresisDb),
		.holdLength(holdLength_reg),
		.attackStep(attackStep_reg),
		.decayStep(decayStep_reg),
		.gainReduction(gainReductionLeft),
		.holding(holdingLeft)
	);

	rc_channel rightChannel (
		.clk(clk),
		.resetn(resetn),
		.enable(compressRight),
		.sampleTick(sampleTick),
		.levelAtten(levelAttenRight),
		.thresholdDb(thresholdDb),
		.hysteresisDb(hysteresisDb),
		.holdLength(holdLength_reg),
		.attackStep(attackStep_reg),
		.decayStep(decayStep_reg),
		.gainReduction(gainReductionRight),
		.holding(holdingRight)
	);

endmodule

/* File: tb/rc_compressor_ctrl_monitor.sv */
// Assertion checker for the range compressor control block
`timescale 1ns/10ps
module rc_compressor_ctrl_monitor (
	clk,
	resetn,
	regAddr,
	regWrData,
	regWrite,
	sampleTick,
	levelAttenLeft,
	volLinkMode,
	compressLeft,
	compressRight,
	gainReductionLeft,
	holdingLeft,
	thresholdDb,
	hysteresisDb
);
	input wire clk, resetn, regWrite, sampleTick, compressLeft, compressRight, holdingLeft;
	input wire [7:0] regAddr, regWrData, levelAttenLeft;
	input wire [27:0] gainReductionLeft;
	input wire [4:0] thresholdDb;
	input wire [1:0] hysteresisDb, volLinkMode;
	logic [3:0] atk, dec, hc;
	logic [17:0] hCnt, hExp;
	logic [28:0] aSum;
	logic [27:0] dStep;
	logic [4:0] thr;
	logic wr44, over, tk;
	assign wr44 = regWrite && regAddr == 8'h44;
	assign tk = sampleTick && compressLeft;
	assign over = levelAttenLeft < {3'h0, thresholdDb};
	assign thr = (regWrData[4:2] == 3'h7) ? 5'h15 : 5'h03 * ({2'h0, regWrData[4:2]} + 5'h01);
	assign aSum = {1'b0, gainReductionLeft} + (29'h0800000 >> atk);
	assign dStep = 28'h0008000 >> dec;
	assign hExp = (hc < 4'hD) ? 18'h00020 << (hc - 4'h1) :
		(hc == 4'hD) ? 18'h18000 : (hc == 4'hE) ? 18'h20000 : 18'h28000;
	////////////////////////////////////////////////////////////////
	// Shadow of the rate and hold codes, and ticks since the last over-threshold tick
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			atk <= 4'h0;
			dec <= 4'h0;
			hc <= 4'h7;
			hCnt <= 18'h00000;
		end else begin
			if (regWrite && regAddr == 8'h45)
				hc <= regWrData[6:3];
			if (regWrite && regAddr == 8'h46) begin
				atk <= regWrData[7:4];
				dec <= regWrData[3:0];
			end
			if (tk)
				hCnt <= over ? 18'h00000 : hCnt + 18'h00001;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence atkTick;
		tk && over;
	endsequence
	sequence relTick;
		tk && !holdingLeft && levelAttenLeft > {3'h0, thresholdDb} + {6'h00, hysteresisDb};
	endsequence
	// Decoded settings leave their flip-flops one edge after the write edge and are checked at the second
	chk_left_enable: assert property (wr44 |=> ##1
		compressLeft == $past(regWrData[6], 2)) else $error("left enable");
	chk_threshold_decode: assert property (wr44 |=> ##1
		thresholdDb == $past(thr, 2)) else $error("threshold");
	chk_hyst_decode: assert property (wr44 |=> ##1
		hysteresisDb == $past(regWrData[1:0], 2)) else $error("hysteresis");
	chk_link_forced: assert property (compressLeft || compressRight |-> volLinkMode == 2'h0)
		else $error("volume link");
	chk_bypass_clear: assert property (!compressLeft |=> gainReductionLeft == 28'h0)
		else $error("bypass gain");
	chk_attack_step: assert property (atkTick |=> gainReductionLeft ==
		($past(aSum[28]) ? 28'hFFFFFFF : $past(aSum[27:0]))) else $error("attack");
	chk_hold_load: assert property (atkTick |=> holdingLeft == (hc != 4'h0))
		else $error("hold load");
	chk_decay_step: assert property (relTick |=> gainReductionLeft ==
		$past(gainReductionLeft > dStep ? gainReductionLeft - dStep : 28'h0)) else $error("decay");
	chk_hold_length: assert property ($fell(holdingLeft) && compressLeft |-> hCnt == hExp)
		else $error("hold length");
endmodule

bind rc_compressor_ctrl rc_compressor_ctrl_monitor mon (.clk(clk), .resetn(resetn),
	.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .sampleTick(sampleTick),
	.levelAttenLeft(levelAttenLeft), .volLinkMode(volLinkMode), .compressLeft(compressLeft),
	.compressRight(compressRight), .gainReductionLeft(gainReductionLeft),
	.holdingLeft(holdingLeft), .thresholdDb(thresholdDb), .hysteresisDb(hysteresisDb));

/* File: tb/rc_compressor_ctrl_tb.sv */
// Self-checking testbench of the range compressor control block
`timescale 1ns/10ps
module rc_compressor_ctrl_tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic sampleTick = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic [7:0] lvlL = 8'h00;
	logic [7:0] lvlR = 8'h00;
	logic [1:0] linkReq = 2'h1;
	logic [7:0] rdData;
	logic [1:0] linkMode, hyst;
	logic [4:0] thr;
	logic cmpL, cmpR, holdL, holdR;
	logic [27:0] gainL, gainR, n;
	int errorCnt = 0;
	int checked = 0;
	always #25 clk = ~clk;
	rc_compressor_ctrl dut (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(rdData), .sampleTick(sampleTick),
		.levelAttenLeft(lvlL), .levelAttenRight(lvlR), .volLinkRequest(linkReq),
		.volLinkMode(linkMode), .compressLeft(cmpL), .compressRight(cmpR),
		.gainReductionLeft(gainL), .gainReductionRight(gainR), .holdingLeft(holdL),
		.holdingRight(holdR), .thresholdDb(thr), .hysteresisDb(hyst));
	////////////////////////////////////////////////////////////////
	task cmp(input logic [27:0] got, input logic [27:0] exp);
		checked++;
		if (got !== exp) begin
			errorCnt++;
			$display("MISMATCH %0t got %0h want %0h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regAddr = a;
		regWrData = d;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge clk);
		regRead = 1'b0;
		cmp(rdData, e);
	endtask
	task tick;
		@(negedge clk);
		sampleTick = 1'b1;
		@(negedge clk);
		sampleTick = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	task t_regs;
		rd(8'h44, 8'h0F);
		rd(8'h45, 8'h38);
		rd(8'h47, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(8'h44, {3'h0, i[2:0], i[1:0]});
			@(negedge clk);
			cmp(thr, (i == 7) ? 28'h15 : 28'(3 * (i + 1)));
			cmp(hyst, i[1:0]);
		end
		wr(8'h45, 8'h78);
		rd(8'h45, 8'h78);
		$display("t_regs done");
	endtask
	task t_attack;
		for (int a = 0; a < 16; a++) begin
			wr(8'h44, 8'h0C);
			wr(8'h46, {a[3:0], 4'h0});
			wr(8'h44, 8'h4C);
			tick;
			cmp(gainL, 28'h0800000 >> a);
			cmp(gainR, 28'h0);
			cmp(linkMode, 2'h0);
			cmp(cmpL, 28'h1);
			cmp(cmpR, 28'h0);
		end
		wr(8'h44, 8'h0C);
		repeat (2) @(negedge clk);
		cmp(gainL, 28'h0);
		cmp(linkMode, 2'h1);
		$display("t_attack done");
	endtask
	task t_hold;
		for (int c = 0; c < 4; c++) begin
			wr(8'h45, {1'b0, c[3:0], 3'h0});
			wr(8'h44, 8'h6C);
			lvlL = 8'h00;
			tick;
			cmp(holdR, (c == 0) ? 28'h0 : 28'h1);
			lvlL = 8'h20;
			n = 28'h0;
			while (holdL === 1'b1 && n < 28'h200) begin
				tick;
				n++;
			end
			cmp(n, (c == 0) ? 28'h0 : 28'h20 << (c - 1));
			wr(8'h44, 8'h0C);
		end
		$display("t_hold done");
	endtask
	task t_decay;
		wr(8'h45, 8'h00);
		for (int d = 0; d < 16; d++) begin
			wr(8'h44, 8'h0C);
			wr(8'h46, {4'h0, d[3:0]});
			wr(8'h44, 8'h6C);
			lvlL = 8'h00;
			lvlR = 8'h00;
			tick;
			cmp(holdR, 28'h0);
			cmp(cmpR, 28'h1);
			lvlL = 8'h10;
			lvlR = 8'h10;
			tick;
			cmp(gainL, 28'h0800000 - (28'h0008000 >> d));
			cmp(gainR, 28'h0800000 - (28'h0008000 >> d));
		end
		wr(8'h44, 8'h6F);
		lvlL = 8'h0F;
		tick;
		cmp(gainL, 28'h07FFFFF);
		$display("t_decay done");
	endtask
	task close_out;
		$display("Comparisons %0d, mismatches %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		t_regs;
		t_attack;
		t_hold;
		t_decay;
		close_out;
	end
	initial begin
		#2000000;
		errorCnt++;
		$display("MISMATCH %0t watchdog", $time);
		close_out;
	end
endmodule
